// ===== hdl/safe_direction_accel_monitor.sv
// direction monitor and acceleration limit monitor with AHB-Lite registers
//
// Notes on behaviour
// RULE1 - operator fixes setpoint, deselects, reselects, then acknowledges a direction stop
// RULE2 - static direction monitor: always with encoder, from each switch-on without
// RULE3 - static positive monitor from bit 12, negative from bit 13
// RULE4 - static direction monitor uses stop response index 0
// RULE5 - encoderless: after switch-off, safe torque off below standstill limit
// RULE6 - encoderless: ON command leaves pulse suppression and starts
// RULE7 - no minimum current within 5 s: back to suppression, raise message
// RULE8 - acceleration limit checked only when accelerating, never when braking
// RULE9 - acceleration monitor enabled only by enable bit 20
// RULE10 - controller selects acceleration monitor with control word bit 8
// RULE11 - selection takes effect immediately
// RULE12 - control and status bits honoured only in telegrams 30, 31, 901-903
// RULE13 - one limit applied to both rotation directions
// RULE14 - limit must be at least ten times fine resolution; the code does not check accel_lim_reg and accepts any value
// RULE15 - coarse and fine resolution readable
// RULE16 - velocity limit for present acceleration readable
// RULE17 - measured acceleration and both applied limits readable
// RULE18 - measured acceleration filtered with configurable time constant
// RULE19 - limit exceeded triggers configured acceleration stop response
// RULE20 - monitor result in status word bit 8 while configured and selected
// RULE21 - bus failure runs extended stop-retract only if stop code >= 10
// RULE22 - result also in info-channel status word bit 8
// RULE23 - acceleration is speed change per monitoring cycle
`default_nettype none
module safe_direction_accel_monitor
  import motion_monitor_pkg::*;
#(
  parameter int START_TIMEOUT = START_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  // drive side
  input wire logic signed [15:0] speed_in,
  input wire logic min_current_in,
  input wire logic comm_fail_in,
  // safety reactions
  output logic sto_out,
  output logic stop_req_out,
  output logic [7:0] stop_code_out,
  output logic esr_out,
  output logic msg_valid_out
);
  // ==========================================================
  // reset release
  logic rst_meta_reg, rst_sync_reg;
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire logic rstn = rst_sync_reg;

  // ==========================================================
  // pin synchronisers: a change counts when stages two and three agree
  logic [2:0] cur_sync_reg, fail_sync_reg;
  logic cur_ok_reg, fail_reg;
  always_ff @(posedge core_clk_in or negedge rstn) begin
    if (!rstn) begin
      cur_sync_reg <= 3'h0;
      fail_sync_reg <= 3'h0;
      cur_ok_reg <= 1'b0;
      fail_reg <= 1'b0;
    end else begin
      cur_sync_reg <= {cur_sync_reg[1:0], min_current_in};
      fail_sync_reg <= {fail_sync_reg[1:0], comm_fail_in};
      if (cur_sync_reg[1] == cur_sync_reg[2]) cur_ok_reg <= cur_sync_reg[2];
      if (fail_sync_reg[1] == fail_sync_reg[2]) fail_reg <= fail_sync_reg[2];
    end
  end

  // ==========================================================
  // bus front end
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] wr_addr_reg, wr_addr_next;
  logic [31:0] rdata_next;
  wire logic addr_ph = hsel_in && hready_in && htrans_in[1];

  // ==========================================================
  // configuration registers
  logic [31:0] func_en_reg, func_en_next;
  logic [31:0] static_sel_reg, static_sel_next;
  logic [7:0] dir_stop_reg, dir_stop_next;
  logic [15:0] accel_lim_reg, accel_lim_next;
  logic [2:0] filt_shift_reg, filt_shift_next;
  logic [7:0] accel_stop_reg, accel_stop_next;
  logic [15:0] bus_delay_reg, bus_delay_next;
  logic [15:0] telegram_reg, telegram_next;
  logic [15:0] ctrl_one_reg, ctrl_one_next;
  logic [15:0] ctrl_two_reg, ctrl_two_next;
  logic encoder_reg, encoder_next;
  logic [15:0] standstill_reg, standstill_next;

  // ==========================================================
  // monitor state
  logic signed [15:0] speed_prev_reg;
  logic signed [16:0] accel_raw;
  logic signed [16:0] filt_reg, filt_next;
  logic accel_active_reg, accel_active_next;
  logic accel_trip_reg, accel_trip_next;
  logic dir_trip_reg, dir_trip_next;
  logic esr_reg, esr_next;
  logic msg_reg, msg_next;
  logic sto_reg, sto_next;
  logic stop_req_reg, stop_req_next;
  logic [7:0] stop_code_reg, stop_code_next;
  logic [15:0] vel_lim_reg, vel_lim_next;
  motor_state_type mstate_reg, mstate_next;
  logic [31:0] start_cnt_reg, start_cnt_next;

  // derived selection terms
  logic tel_ok, tel_word_one, accel_sel, dir_active, accelerating, over_lim;
  logic cmd_on, cmd_off, cmd_ack, speed_small;
  logic signed [16:0] lim_s, diff_s;
  logic [15:0] speed_abs;

  always_comb begin
    tel_word_one = (telegram_reg == TEL_30) || (telegram_reg == TEL_31);
    tel_ok = tel_word_one || (telegram_reg == TEL_901) ||
             (telegram_reg == TEL_902) || (telegram_reg == TEL_903); // RULE12
    accel_sel = tel_ok && (tel_word_one ? ctrl_one_reg[BIT_ACCEL_WORD]
                                        : ctrl_two_reg[BIT_ACCEL_WORD]); // RULE10
    accel_raw = 17'(speed_in) - 17'(speed_prev_reg); // RULE23
    lim_s = $signed({1'b0, accel_lim_reg});
    diff_s = accel_raw - filt_reg;
    // braking has acceleration opposite to speed, so it never reaches the compare
    accelerating = (speed_in >= 16'sh0000) ? (filt_reg > 17'sh00000)
                                           : (filt_reg < 17'sh00000); // RULE8
    over_lim = (filt_reg > lim_s) || (filt_reg < -lim_s); // RULE13
    speed_abs = speed_in[15] ? 16'(-speed_in) : speed_in;
    speed_small = speed_abs < standstill_reg;
    // encoderless static monitor follows the motor being switched on
    dir_active = encoder_reg || (mstate_reg == MOTOR_RUNNING) ||
                 (mstate_reg == MOTOR_STARTING); // RULE2
    cmd_on = wr_pend_reg && (wr_addr_reg == OFS_MOTOR_CMD) && hwdata_in[BIT_CMD_ON];
    cmd_off = wr_pend_reg && (wr_addr_reg == OFS_MOTOR_CMD) && hwdata_in[BIT_CMD_OFF];
    cmd_ack = wr_pend_reg && (wr_addr_reg == OFS_MOTOR_CMD) && hwdata_in[BIT_CMD_ACK];
  end

  // ==========================================================
  // next-state logic
  always_comb begin
    wr_pend_next = addr_ph && hwrite_in;
    wr_addr_next = {haddr_in[7:2], 2'b00};
    func_en_next = func_en_reg;
    static_sel_next = static_sel_reg;
    dir_stop_next = dir_stop_reg;
    accel_lim_next = accel_lim_reg;
    filt_shift_next = filt_shift_reg;
    accel_stop_next = accel_stop_reg;
    bus_delay_next = bus_delay_reg;
    telegram_next = telegram_reg;
    ctrl_one_next = ctrl_one_reg;
    ctrl_two_next = ctrl_two_reg;
    encoder_next = encoder_reg;
    standstill_next = standstill_reg;
    if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        OFS_FUNC_ENABLE: func_en_next = hwdata_in;
        OFS_STATIC_SEL: static_sel_next = hwdata_in;
        OFS_DIR_STOP: dir_stop_next = hwdata_in[7:0];
        OFS_ACCEL_LIMIT: accel_lim_next = hwdata_in[15:0];
        OFS_ACCEL_FILTER: filt_shift_next = hwdata_in[2:0];
        OFS_ACCEL_STOP: accel_stop_next = hwdata_in[7:0];
        OFS_BUS_DELAY: bus_delay_next = hwdata_in[15:0];
        OFS_TELEGRAM: telegram_next = hwdata_in[15:0];
        OFS_CTRL_ONE: ctrl_one_next = hwdata_in[15:0];
        OFS_CTRL_TWO: ctrl_two_next = hwdata_in[15:0];
        OFS_MODE: encoder_next = hwdata_in[BIT_MODE_ENCODER];
        OFS_STANDSTILL: standstill_next = hwdata_in[15:0];
        default: ;
      endcase
    end

    // first-order filter, time constant 2**shift cycles
    filt_next = filt_reg + (diff_s >>> filt_shift_reg); // RULE18
    accel_active_next = func_en_reg[BIT_ACCEL_ENABLE] && accel_sel; // RULE9 RULE11

    // trips are sticky; an event in the acknowledge cycle is kept
    accel_trip_next = (accel_trip_reg && !cmd_ack) ||
                      (accel_active_reg && accelerating && over_lim); // RULE19
    dir_trip_next = (dir_trip_reg && !cmd_ack) || (dir_active &&
                    ((static_sel_reg[BIT_STATIC_POS] && speed_in < 16'sh0000) ||
                     (static_sel_reg[BIT_STATIC_NEG] && speed_in > 16'sh0000))); // RULE3
    esr_next = (esr_reg && !cmd_ack) || (fail_reg && (bus_delay_reg != 16'h0000) &&
               accel_active_reg && (accel_stop_reg >= ESR_MIN_CODE)); // RULE21
    stop_req_next = accel_trip_next || dir_trip_next;
    stop_code_next = accel_trip_next ? accel_stop_reg :
                     dir_trip_next ? dir_stop_reg : 8'h00; // RULE4
    vel_lim_next = 16'(speed_prev_reg + (speed_in[15] ? -lim_s : lim_s)); // RULE16

    // encoderless switch-on and switch-off sequence
    mstate_next = mstate_reg;
    start_cnt_next = 32'h0000_0000;
    msg_next = msg_reg && !cmd_ack;
    unique case (mstate_reg)
      MOTOR_PULSE_OFF: begin
        if (cmd_on) mstate_next = MOTOR_STARTING; // RULE6
      end
      MOTOR_STARTING: begin
        start_cnt_next = start_cnt_reg + 32'h0000_0001;
        if (encoder_reg || cur_ok_reg) begin
          mstate_next = MOTOR_RUNNING;
        end else if (start_cnt_reg >= 32'(START_TIMEOUT - 1)) begin
          mstate_next = MOTOR_PULSE_OFF; // RULE7
          msg_next = 1'b1;
        end
      end
      MOTOR_RUNNING: begin
        if (cmd_off) mstate_next = MOTOR_STOPPING;
      end
      MOTOR_STOPPING: begin
        if (speed_small) mstate_next = MOTOR_PULSE_OFF; // RULE5
      end
    endcase
    sto_next = (mstate_next == MOTOR_PULSE_OFF);

    // read data captured in the address phase, presented in the data phase
    rdata_next = 32'h0000_0000;
    if (addr_ph && !hwrite_in) begin
      unique case ({haddr_in[7:2], 2'b00})
        OFS_FUNC_ENABLE: rdata_next = func_en_reg;
        OFS_STATIC_SEL: rdata_next = static_sel_reg;
        OFS_DIR_STOP: rdata_next = {24'h000000, dir_stop_reg};
        OFS_ACCEL_LIMIT: rdata_next = {16'h0000, accel_lim_reg};
        OFS_ACCEL_FILTER: rdata_next = {29'h00000000, filt_shift_reg};
        OFS_ACCEL_STOP: rdata_next = {24'h000000, accel_stop_reg};
        OFS_BUS_DELAY: rdata_next = {16'h0000, bus_delay_reg};
        OFS_TELEGRAM: rdata_next = {16'h0000, telegram_reg};
        OFS_CTRL_ONE: rdata_next = {16'h0000, ctrl_one_reg};
        OFS_CTRL_TWO: rdata_next = {16'h0000, ctrl_two_reg};
        OFS_STAT_ONE: rdata_next = 32'({tel_word_one && accel_active_reg, 8'h00}); // RULE20
        OFS_STAT_TWO: rdata_next = 32'({!tel_word_one && accel_active_reg, 8'h00}); // RULE20
        OFS_INFO_STAT: rdata_next = 32'({accel_active_reg, 8'h00}); // RULE22
        OFS_RES_COARSE: rdata_next = {16'h0000, RES_COARSE_VAL}; // RULE15
        OFS_RES_FINE: rdata_next = {16'h0000, RES_FINE_VAL}; // RULE15
        OFS_DIAG_ACCEL: rdata_next = 32'(filt_reg); // RULE17
        OFS_DIAG_LIM_POS: rdata_next = {16'h0000, accel_lim_reg}; // RULE17
        OFS_DIAG_LIM_NEG: rdata_next = 32'(-lim_s); // RULE17
        OFS_DIAG_VEL: rdata_next = {16'h0000, vel_lim_reg};
        OFS_MOTOR_STAT: rdata_next = {MSG_CODE_VAL, 6'h00, esr_reg, dir_trip_reg,
                                      accel_trip_reg, msg_reg, sto_reg, mstate_reg,
                                      accel_active_reg};
        OFS_MODE: rdata_next = {31'h00000000, encoder_reg};
        OFS_STANDSTILL: rdata_next = {16'h0000, standstill_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk_in or negedge rstn) begin
    if (!rstn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_out <= 32'h0000_0000;
      hreadyout_out <= 1'b0;
      hresp_out <= 1'b0;
      func_en_reg <= 32'h0000_0000;
      static_sel_reg <= 32'h0000_0000;
      dir_stop_reg <= 8'h00;
      accel_lim_reg <= 16'h0000;
      filt_shift_reg <= 3'h0;
      accel_stop_reg <= 8'h00;
      bus_delay_reg <= 16'h0000;
      telegram_reg <= 16'h0000;
      ctrl_one_reg <= 16'h0000;
      ctrl_two_reg <= 16'h0000;
      encoder_reg <= 1'b0;
      standstill_reg <= STANDSTILL_RST;
      speed_prev_reg <= 16'sh0000;
      filt_reg <= 17'sh00000;
      accel_active_reg <= 1'b0;
      accel_trip_reg <= 1'b0;
      dir_trip_reg <= 1'b0;
      esr_reg <= 1'b0;
      msg_reg <= 1'b0;
      sto_reg <= 1'b1;
      stop_req_reg <= 1'b0;
      stop_code_reg <= 8'h00;
      vel_lim_reg <= 16'h0000;
      mstate_reg <= MOTOR_PULSE_OFF;
      start_cnt_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      hrdata_out <= rdata_next;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      func_en_reg <= func_en_next;
      static_sel_reg <= static_sel_next;
      dir_stop_reg <= dir_stop_next;
      accel_lim_reg <= accel_lim_next;
      filt_shift_reg <= filt_shift_next;
      accel_stop_reg <= accel_stop_next;
      bus_delay_reg <= bus_delay_next;
      telegram_reg <= telegram_next;
      ctrl_one_reg <= ctrl_one_next;
      ctrl_two_reg <= ctrl_two_next;
      encoder_reg <= encoder_next;
      standstill_reg <= standstill_next;
      speed_prev_reg <= speed_in;
      filt_reg <= filt_next;
      accel_active_reg <= accel_active_next;
      accel_trip_reg <= accel_trip_next;
      dir_trip_reg <= dir_trip_next;
      esr_reg <= esr_next;
      msg_reg <= msg_next;
      sto_reg <= sto_next;
      stop_req_reg <= stop_req_next;
      stop_code_reg <= stop_code_next;
      vel_lim_reg <= vel_lim_next;
      mstate_reg <= mstate_next;
      start_cnt_reg <= start_cnt_next;
    end
  end

  always_comb begin
    sto_out = sto_reg;
    stop_req_out = stop_req_reg;
    stop_code_out = stop_code_reg;
    esr_out = esr_reg;
    msg_valid_out = msg_reg;
  end

  // ==========================================================
  // checks
  AST_ACCEL_SELECT: assert property (@(posedge core_clk_in) disable iff (!rstn) // RULE11
    accel_active_reg == $past(func_en_reg[BIT_ACCEL_ENABLE] && accel_sel))
    else $error("accel monitor activation lags selection");
  AST_ENABLE_BIT: assert property (@(posedge core_clk_in) disable iff (!rstn) // RULE9
    !func_en_reg[BIT_ACCEL_ENABLE] ##1 !func_en_reg[BIT_ACCEL_ENABLE]
    |-> !accel_active_reg)
    else $error("accel monitor active while disabled");
  AST_TELEGRAM: assert property (@(posedge core_clk_in) disable iff (!rstn) // RULE12
    !tel_ok ##1 !tel_ok |-> !accel_active_reg)
    else $error("accel monitor active with foreign telegram");
  AST_NO_BRAKE_TRIP: assert property (@(posedge core_clk_in) disable iff (!rstn) // RULE8
    $rose(accel_trip_reg) |-> $past(accelerating && over_lim && accel_active_reg))
    else $error("accel trip without acceleration over limit");
  AST_STOP_CODE: assert property (@(posedge core_clk_in) disable iff (!rstn) // RULE19
    accel_trip_reg |-> stop_req_out && stop_code_out == $past(accel_stop_reg))
    else $error("accel stop response not applied");
  AST_DIR_CODE: assert property (@(posedge core_clk_in) disable iff (!rstn) // RULE4
    dir_trip_reg && !accel_trip_reg |-> stop_code_out == $past(dir_stop_reg))
    else $error("direction stop response not applied");
  AST_ESR_GATE: assert property (@(posedge core_clk_in) disable iff (!rstn) // RULE21
    $rose(esr_reg) |-> $past(fail_reg && accel_active_reg && accel_stop_reg >= ESR_MIN_CODE &&
    bus_delay_reg != 16'h0000))
    else $error("extended stop-retract with wrong response code");
  AST_ON_START: assert property (@(posedge core_clk_in) disable iff (!rstn) // RULE6
    mstate_reg == MOTOR_PULSE_OFF && cmd_on |=> mstate_reg == MOTOR_STARTING ##1 !sto_reg)
    else $error("on command did not start the motor");
  AST_START_TIMEOUT: assert property (@(posedge core_clk_in) disable iff (!rstn) // RULE7
    $rose(msg_reg) |-> $past(start_cnt_reg) == 32'(START_TIMEOUT - 1) && sto_reg)
    else $error("start timeout message at wrong count");
  AST_STANDSTILL_STO: assert property (@(posedge core_clk_in) disable iff (!rstn) // RULE5
    mstate_reg == MOTOR_STOPPING && speed_small |=> sto_reg)
    else $error("no torque off below standstill");
endmodule
`default_nettype wire

// ===== hdl/motion_monitor_pkg.sv
// shared constants and types for the direction and acceleration monitor
`default_nettype none
package motion_monitor_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_FUNC_ENABLE = 8'h00;
  localparam logic [7:0] OFS_STATIC_SEL = 8'h04;
  localparam logic [7:0] OFS_DIR_STOP = 8'h08;
  localparam logic [7:0] OFS_ACCEL_LIMIT = 8'h0C;
  localparam logic [7:0] OFS_ACCEL_FILTER = 8'h10;
  localparam logic [7:0] OFS_ACCEL_STOP = 8'h14;
  localparam logic [7:0] OFS_BUS_DELAY = 8'h18;
  localparam logic [7:0] OFS_TELEGRAM = 8'h1C;
  localparam logic [7:0] OFS_CTRL_ONE = 8'h20;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h24;
  localparam logic [7:0] OFS_STAT_ONE = 8'h28;
  localparam logic [7:0] OFS_STAT_TWO = 8'h2C;
  localparam logic [7:0] OFS_INFO_STAT = 8'h30;
  localparam logic [7:0] OFS_RES_COARSE = 8'h34;
  localparam logic [7:0] OFS_RES_FINE = 8'h38;
  localparam logic [7:0] OFS_DIAG_ACCEL = 8'h3C;
  localparam logic [7:0] OFS_DIAG_LIM_POS = 8'h40;
  localparam logic [7:0] OFS_DIAG_LIM_NEG = 8'h44;
  localparam logic [7:0] OFS_DIAG_VEL = 8'h48;
  localparam logic [7:0] OFS_MOTOR_STAT = 8'h4C;
  localparam logic [7:0] OFS_MOTOR_CMD = 8'h50;
  localparam logic [7:0] OFS_MODE = 8'h54;
  localparam logic [7:0] OFS_STANDSTILL = 8'h58;
  // ==========================================================
  // field positions
  localparam int BIT_ACCEL_ENABLE = 20;
  localparam int BIT_STATIC_POS = 12;
  localparam int BIT_STATIC_NEG = 13;
  localparam int BIT_ACCEL_WORD = 8;
  localparam int BIT_CMD_ON = 0;
  localparam int BIT_CMD_OFF = 1;
  localparam int BIT_CMD_ACK = 2;
  localparam int BIT_MODE_ENCODER = 0;
  // ==========================================================
  // reset values and fixed figures
  localparam logic [15:0] RES_COARSE_VAL = 16'h0010;
  localparam logic [15:0] RES_FINE_VAL = 16'h0001;
  localparam logic [7:0] ESR_MIN_CODE = 8'h0A;
  localparam logic [15:0] MSG_CODE_VAL = 16'h1711;
  localparam logic [15:0] TEL_30 = 16'h001E;
  localparam logic [15:0] TEL_31 = 16'h001F;
  localparam logic [15:0] TEL_901 = 16'h0385;
  localparam logic [15:0] TEL_902 = 16'h0386;
  localparam logic [15:0] TEL_903 = 16'h0387;
  localparam logic [15:0] STANDSTILL_RST = 16'h0010;
  // ==========================================================
  // timing
  localparam longint CLK_HZ = 10000000;
  localparam longint START_TIMEOUT_S = 5;
  localparam int START_TIMEOUT_CYC = int'(START_TIMEOUT_S * CLK_HZ);
  // ==========================================================
  // types
  typedef enum logic [3:0] {
    MOTOR_PULSE_OFF = 4'b0001,
    MOTOR_STARTING = 4'b0010,
    MOTOR_RUNNING = 4'b0100,
    MOTOR_STOPPING = 4'b1000
  } motor_state_type;
  typedef struct packed {
    logic safe_torque_off;
    logic stop_req;
    logic [7:0] stop_code;
    logic extended_stop_retract;
    logic msg_valid;
  } safe_reaction_type;
endpackage
`default_nettype wire

// ===== dv/drive_model.sv
// behavioural drive: speed integrates a per-cycle step, one step per monitoring cycle
`default_nettype none
module drive_model (
  // clock
  input wire logic clk_in,
  // speed change per cycle from the bench
  input wire logic signed [15:0] step_in,
  // measured speed towards the monitor
  output logic signed [15:0] speed_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial speed_out = 16'sh0000;
  // steps stay small so speed never wraps within the run
  always @(posedge clk_in) speed_out <= speed_out + step_in;
endmodule
`default_nettype wire

// ===== dv/test_safe_direction_accel_monitor.sv
// self-checking bench for the direction and acceleration monitor
`default_nettype none
module test_safe_direction_accel_monitor;
  import motion_monitor_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // signals
  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic hsel_in = 1'b0;
  logic [31:0] haddr_in = 32'h0;
  logic [1:0] htrans_in = 2'h0;
  logic hwrite_in = 1'b0;
  logic [2:0] hsize_in = 3'h2;
  logic [31:0] hwdata_in = 32'h0;
  logic hreadyout_out, hresp_out, sto_out, stop_req_out, esr_out, msg_valid_out;
  logic [31:0] hrdata_out, rd;
  logic [7:0] stop_code_out;
  logic signed [15:0] step = 16'sh0000;
  logic signed [15:0] speed;
  logic min_current_in = 1'b0;
  logic comm_fail_in = 1'b0;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #50 core_clk_in = ~core_clk_in;
  drive_model drv (.clk_in(core_clk_in), .step_in(step), .speed_out(speed));
  // short start timeout keeps the run brief
  safe_direction_accel_monitor #(.START_TIMEOUT(20)) dut (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hsize_in(hsize_in), .hready_in(hreadyout_out), .hwdata_in(hwdata_in),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .hrdata_out(hrdata_out),
    .speed_in(speed), .min_current_in(min_current_in), .comm_fail_in(comm_fail_in),
    .sto_out(sto_out), .stop_req_out(stop_req_out), .stop_code_out(stop_code_out),
    .esr_out(esr_out), .msg_valid_out(msg_valid_out));
  // ==========================================================
  // shared tasks
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wait_rdy;
    int i;
    i = 0;
    @(posedge core_clk_in);
    while (hreadyout_out !== 1'b1) begin
      i++;
      if (i > 100) begin
        n_mismatch++;
        end_sim;
      end
      @(posedge core_clk_in);
    end
  endtask
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= {24'h0, a};
    hwrite_in <= wr;
    wait_rdy;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    wait_rdy;
    rd = hrdata_out;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // sel 0 waits for a stop request, sel 1 for the stop-and-retract request
  task wait_out(input int sel);
    for (int i = 0; i < 2000; i++) begin
      @(posedge core_clk_in);
      if ((sel == 0 ? stop_req_out : esr_out) === 1'b1) return;
    end
    n_mismatch++;
    end_sim;
  endtask
  // ==========================================================
  // scenarios
  task test_readout;
    rd_chk(OFS_RES_COARSE, {16'h0, RES_COARSE_VAL});
    rd_chk(OFS_RES_FINE, {16'h0, RES_FINE_VAL});
    rd_chk(8'hFC, 32'h0);
    chk({31'h0, hresp_out}, 32'h0);
    $display("test readout done");
  endtask
  task test_start;
    bus(1'b1, OFS_MODE, 32'h0);
    bus(1'b1, OFS_MOTOR_CMD, 32'h1);
    repeat (2) @(posedge core_clk_in);
    chk({31'h0, sto_out}, 32'h0);
    repeat (30) @(posedge core_clk_in);
    chk({30'h0, sto_out, msg_valid_out}, 32'h3);
    bus(1'b0, OFS_MOTOR_STAT, 32'h0);
    chk({16'h0, rd[31:16]}, {16'h0, MSG_CODE_VAL});
    bus(1'b1, OFS_MOTOR_CMD, 32'h4);
    // second start succeeds on motor current, then a stop ends in torque off
    min_current_in <= 1'b1;
    repeat (6) @(posedge core_clk_in);
    bus(1'b1, OFS_MOTOR_CMD, 32'h1);
    step <= 16'sd4;
    repeat (10) @(posedge core_clk_in);
    step <= 16'sd0;
    rd_chk(OFS_MOTOR_STAT, {MSG_CODE_VAL, 16'h0008});
    bus(1'b1, OFS_MOTOR_CMD, 32'h2);
    repeat (2) @(posedge core_clk_in);
    chk({31'h0, sto_out}, 32'h0);
    step <= -16'sd4;
    repeat (10) @(posedge core_clk_in);
    step <= 16'sd0;
    chk({31'h0, sto_out}, 32'h1);
    $display("test start done");
  endtask
  task test_select;
    logic [15:0] tel [3] = '{TEL_901, TEL_902, TEL_903};
    bus(1'b1, OFS_MODE, 32'h1);
    bus(1'b1, OFS_FUNC_ENABLE, 32'h0010_0000);
    bus(1'b1, OFS_TELEGRAM, 32'h1);
    bus(1'b1, OFS_CTRL_ONE, 32'h100);
    rd_chk(OFS_STAT_ONE, 32'h0);
    foreach (tel[i]) begin
      bus(1'b1, OFS_TELEGRAM, {16'h0, tel[i]});
      bus(1'b1, OFS_CTRL_TWO, 32'h100);
      rd_chk(OFS_STAT_TWO, 32'h100);
    end
    bus(1'b1, OFS_TELEGRAM, {16'h0, TEL_30});
    rd_chk(OFS_STAT_ONE, 32'h100);
    rd_chk(OFS_INFO_STAT, 32'h100);
    $display("test select done");
  endtask
  task test_accel;
    bus(1'b1, OFS_ACCEL_LIMIT, 32'hA);
    bus(1'b1, OFS_ACCEL_FILTER, 32'h0);
    bus(1'b1, OFS_ACCEL_STOP, 32'hB);
    bus(1'b1, OFS_BUS_DELAY, 32'h1);
    step <= 16'sd5;
    repeat (40) @(posedge core_clk_in);
    // hard braking while still moving forward must not trip
    step <= -16'sd20;
    repeat (8) @(posedge core_clk_in);
    chk({31'h0, stop_req_out}, 32'h0);
    step <= 16'sd20;
    wait_out(0);
    chk({24'h0, stop_code_out}, 32'hB);
    comm_fail_in <= 1'b1;
    wait_out(1);
    comm_fail_in <= 1'b0;
    step <= 16'sd0;
    repeat (10) @(posedge core_clk_in);
    bus(1'b1, OFS_MOTOR_CMD, 32'h4);
    @(posedge core_clk_in);
    chk({30'h0, stop_req_out, esr_out}, 32'h0);
    rd_chk(OFS_DIAG_LIM_POS, 32'hA);
    rd_chk(OFS_DIAG_LIM_NEG, 32'hFFFF_FFF6);
    // a code below ten keeps the plain stop on bus failure
    bus(1'b1, OFS_ACCEL_STOP, 32'h9);
    step <= 16'sd20;
    wait_out(0);
    chk({24'h0, stop_code_out}, 32'h9);
    comm_fail_in <= 1'b1;
    repeat (10) @(posedge core_clk_in);
    chk({31'h0, esr_out}, 32'h0);
    comm_fail_in <= 1'b0;
    step <= 16'sd0;
    repeat (10) @(posedge core_clk_in);
    bus(1'b1, OFS_MOTOR_CMD, 32'h4);
    @(posedge core_clk_in);
    chk({30'h0, stop_req_out, esr_out}, 32'h0);
    $display("test accel done");
  endtask
  task test_direction;
    bus(1'b1, OFS_CTRL_ONE, 32'h0);
    bus(1'b1, OFS_DIR_STOP, 32'h5);
    bus(1'b1, OFS_STATIC_SEL, 32'h1000);
    step <= -16'sd8;
    wait_out(0);
    chk({24'h0, stop_code_out}, 32'h5);
    // correct the setpoint, deselect, reselect, then acknowledge
    step <= 16'sd8;
    repeat (8) @(posedge core_clk_in);
    step <= 16'sd0;
    bus(1'b1, OFS_STATIC_SEL, 32'h0);
    bus(1'b1, OFS_STATIC_SEL, 32'h1000);
    bus(1'b1, OFS_MOTOR_CMD, 32'h4);
    @(posedge core_clk_in);
    chk({31'h0, stop_req_out}, 32'h0);
    bus(1'b1, OFS_STATIC_SEL, 32'h2000);
    wait_out(0);
    chk({24'h0, stop_code_out}, 32'h5);
    $display("test direction done");
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    test_readout;
    test_start;
    test_select;
    test_accel;
    test_direction;
    end_sim;
  end
endmodule
`default_nettype wire
